// [rtl/tsc_pkg.sv]
// Shared constants for the terminal status control block
package tsc_pkg;

  // Register byte offsets on the APB port
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LAMP = 8'h04;
  localparam logic [7:0] OFS_ATTR = 8'h08;
  localparam logic [7:0] OFS_CFG  = 8'h0C;
  localparam logic [7:0] OFS_IDLE = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_LOUT = 8'h18;

  // Status-control word fields
  localparam int BIT_DISP     = 15;
  localparam int BIT_BUZ_CONT = 13;
  localparam int BIT_BUZ_INT  = 12;
  localparam int BIT_BL_RED   = 11;
  localparam int BIT_BL_FLASH = 10;
  localparam int CHG_LO       = 8;

  // Configuration fields
  localparam int CFG_BLANK_EN = 0;
  localparam int CFG_BLANK_BL = 1;

  // Status register fields
  localparam int STAT_DISP    = 0;
  localparam int STAT_BL      = 1;
  localparam int STAT_RED     = 2;
  localparam int STAT_BUZ     = 3;
  localparam int STAT_BLANK   = 4;
  localparam int STAT_APPLIED = 5;

  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] LAMP_RST = 16'h0000;
  localparam logic [15:0] ATTR_RST = 16'h0000;
  localparam logic [1:0]  CFG_RST  = 2'h0;
  localparam logic [15:0] IDLE_RST = 16'h003C;

  // Timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int FLASH_HALF_MS = 500;
  localparam int BUZZ_HALF_MS  = 250;
  localparam int IDLE_TICK_MS  = 1000;
  localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int BUZZ_HALF_CYC  = (CLK_HZ / 1000) * BUZZ_HALF_MS;
  localparam int IDLE_TICK_CYC  = (CLK_HZ / 1000) * IDLE_TICK_MS;

  typedef enum logic [1:0] {
    BL_WHITE     = 2'b00,
    BL_RED_FLASH = 2'b10,
    BL_RED       = 2'b11
  } tsc_bl_mode_t;

  typedef enum logic {
    IDLE_RUN   = 1'b0,
    IDLE_BLANK = 1'b1
  } tsc_idle_state_t;

endpackage

// [rtl/tsc_flash_timer.sv]
// Free running half-period timer giving a square phase and a tick
`timescale 1ns/1ps
`default_nettype none
module tsc_flash_timer #(
  parameter int HALF_CYC = 20_000_000
) (
  input  wire logic clk,      // Device clock
  input  wire logic srst,     // Synchronous reset
  output logic      phase,    // Square wave, toggles each half period
  output logic      tick      // One-cycle pulse at each half period end
);
  localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  logic [CW-1:0] count_ff;
  logic          phase_ff;
  logic          tick_ff;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count_ff <= '0;
      phase_ff <= 1'b0;
      tick_ff  <= 1'b0;
    end
    else if (count_ff == LAST)
    begin
      count_ff <= '0;
      phase_ff <= ~phase_ff;
      tick_ff  <= 1'b1;
    end
    else
    begin
      count_ff <= count_ff + CW'(1);
      tick_ff  <= 1'b0;
    end
  end

  assign phase = phase_ff;
  assign tick  = tick_ff;
endmodule // tsc_flash_timer
`default_nettype wire

// [rtl/tsc_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
`default_nettype none
module tsc_pin_sync (
  input  wire logic clk,      // Device clock
  input  wire logic srst,     // Synchronous reset
  input  wire logic pinIn,    // Asynchronous pin level
  output logic      level,    // Filtered level
  output logic      rise      // One-cycle pulse on filtered rise
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  logic rise_ff;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= pinIn;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      level_ff <= 1'b0;
      rise_ff  <= 1'b0;
    end
    else
    begin
      rise_ff <= (s2_ff == s3_ff) && s3_ff && !level_ff;
      if (s2_ff == s3_ff)
      begin
        level_ff <= s3_ff;
      end
    end
  end

  assign level = level_ff;
  assign rise  = rise_ff;
endmodule // tsc_pin_sync
`default_nettype wire

// [rtl/tsc_status_control.sv]
// Terminal status-control word decoder with APB register port
// Notes on behaviour
// - Bit 15 clear: backlight off, colour ignored
// - Backlight: white, red flashing, or steady red
// - Blank display or backlight after idle period
// - Ignore word after reset until it changes
// - Display on while bit 15 is set
// - Bit 13 set: buzzer sounds continuously
// - Bit 12 set: buzzer sounds on-off
// - Both buzzer bits clear: buzzer silent
// - Lamp bit 0 unlit, 1 lit
// - Per-lamp attribute selects steady or flashing
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tsc_status_control #(
  parameter int NUM_LAMPS      = 16,
  parameter int FLASH_HALF_CYC = tsc_pkg::FLASH_HALF_CYC,
  parameter int BUZZ_HALF_CYC  = tsc_pkg::BUZZ_HALF_CYC,
  parameter int IDLE_TICK_CYC  = tsc_pkg::IDLE_TICK_CYC
) (
  input  wire logic                 clk,           // Device clock, 40 MHz
  input  wire logic                 srst,          // Synchronous reset, active high
  input  wire logic                 psel,          // APB select
  input  wire logic                 penable,       // APB enable
  input  wire logic                 pwrite,        // APB direction, 1 = write
  input  wire logic [7:0]           paddr,         // APB byte address
  input  wire logic [31:0]          pwdata,        // APB write data
  input  wire logic [3:0]           pstrb,         // APB byte strobes
  output logic      [31:0]          prdata,        // APB read data
  output logic                      pready,        // APB ready
  output logic                      pslverr,       // APB error, unmapped address
  input  wire logic                 touchActivity, // Operator touch pin, async
  output logic                      displayOn,     // Display enable
  output logic                      backlightOn,   // Backlight enable
  output logic                      backlightRed,  // Backlight colour, 1 = red
  output logic                      buzzerOn,      // Buzzer drive
  output logic      [NUM_LAMPS-1:0] lampLit        // Lamp and touch switch lit
);

  localparam int LW = (NUM_LAMPS > 16) ? 16 : NUM_LAMPS;

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == tsc_pkg::OFS_CTRL) || (a == tsc_pkg::OFS_LAMP) ||
               (a == tsc_pkg::OFS_ATTR) || (a == tsc_pkg::OFS_CFG) ||
               (a == tsc_pkg::OFS_IDLE) || (a == tsc_pkg::OFS_STAT) ||
               (a == tsc_pkg::OFS_LOUT);
  endfunction

  // Merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
    mergeLanes = old;
    if (st[0])
    begin
      mergeLanes[7:0] = wd[7:0];
    end
    if (st[1])
    begin
      mergeLanes[15:8] = wd[15:8];
    end
  endfunction

  // Bus decode
  logic        wrAccess;
  logic        rdSetup;
  logic        wrCtrl;
  logic        wrLamp;
  logic        wrAttr;
  logic        wrCfg;
  logic        wrIdle;
  logic        wrStat;

  assign wrAccess = psel && penable && pwrite;
  assign rdSetup  = psel && !penable && !pwrite;
  assign wrCtrl   = wrAccess && (paddr == tsc_pkg::OFS_CTRL);
  assign wrLamp   = wrAccess && (paddr == tsc_pkg::OFS_LAMP);
  assign wrAttr   = wrAccess && (paddr == tsc_pkg::OFS_ATTR);
  assign wrCfg    = wrAccess && (paddr == tsc_pkg::OFS_CFG);
  assign wrIdle   = wrAccess && (paddr == tsc_pkg::OFS_IDLE);
  assign wrStat   = wrAccess && (paddr == tsc_pkg::OFS_STAT);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !isMapped(paddr);

  // Software registers
  logic [15:0] ctrlWord_ff;
  logic [15:0] lampCtrl_ff;
  logic [15:0] lampAttr_ff;
  logic [1:0]  cfg_ff;
  logic [15:0] idlePeriod_ff;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrlWord_ff   <= tsc_pkg::CTRL_RST;
      lampCtrl_ff   <= tsc_pkg::LAMP_RST;
      lampAttr_ff   <= tsc_pkg::ATTR_RST;
      cfg_ff        <= tsc_pkg::CFG_RST;
      idlePeriod_ff <= tsc_pkg::IDLE_RST;
    end
    else
    begin
      if (wrCtrl)
      begin
        ctrlWord_ff <= mergeLanes(ctrlWord_ff, pwdata, pstrb);
      end
      if (wrLamp)
      begin
        lampCtrl_ff <= mergeLanes(lampCtrl_ff, pwdata, pstrb);
      end
      if (wrAttr)
      begin
        lampAttr_ff <= mergeLanes(lampAttr_ff, pwdata, pstrb);
      end
      if (wrCfg && pstrb[0])
      begin
        cfg_ff <= pwdata[1:0];
      end
      if (wrIdle)
      begin
        idlePeriod_ff <= mergeLanes(idlePeriod_ff, pwdata, pstrb);
      end
    end
  end

  // Change detection on the upper byte of the control word
  logic [7:0] shadow_ff;
  logic [7:0] applied_ff;
  logic       ctrlChanged;
  logic       appliedFlag_ff;

  assign ctrlChanged = ctrlWord_ff[15:tsc_pkg::CHG_LO] != shadow_ff;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // Copy and applied state start equal, so nothing acts until a change
      shadow_ff  <= tsc_pkg::CTRL_RST[15:tsc_pkg::CHG_LO];
      applied_ff <= 8'h00;
    end
    else if (ctrlChanged)
    begin
      applied_ff <= ctrlWord_ff[15:tsc_pkg::CHG_LO];
      shadow_ff  <= ctrlWord_ff[15:tsc_pkg::CHG_LO];
    end
  end

  // Sticky applied flag, cleared by writing one; a new change wins
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      appliedFlag_ff <= 1'b0;
    end
    else if (ctrlChanged)
    begin
      appliedFlag_ff <= 1'b1;
    end
    else if (wrStat && pstrb[0] && pwdata[tsc_pkg::STAT_APPLIED])
    begin
      appliedFlag_ff <= 1'b0;
    end
  end

  // Decoded applied fields
  logic                  enDisp;
  logic                  buzCont;
  logic                  buzInt;
  tsc_pkg::tsc_bl_mode_t blMode;

  assign enDisp  = applied_ff[tsc_pkg::BIT_DISP - tsc_pkg::CHG_LO];
  assign buzCont = applied_ff[tsc_pkg::BIT_BUZ_CONT - tsc_pkg::CHG_LO];
  assign buzInt  = applied_ff[tsc_pkg::BIT_BUZ_INT - tsc_pkg::CHG_LO];

  always_comb
  begin
    if (!applied_ff[tsc_pkg::BIT_BL_RED - tsc_pkg::CHG_LO])
    begin
      blMode = tsc_pkg::BL_WHITE;
    end
    else if (applied_ff[tsc_pkg::BIT_BL_FLASH - tsc_pkg::CHG_LO])
    begin
      blMode = tsc_pkg::BL_RED;
    end
    else
    begin
      blMode = tsc_pkg::BL_RED_FLASH;
    end
  end

  // Timing sources
  logic flashPhase;
  logic buzzPhase;
  logic idleTick;
  logic touchLevel;
  logic touchRise;

  tsc_flash_timer #(
    .HALF_CYC (FLASH_HALF_CYC)
  ) uFlash (
    .clk   (clk),
    .srst  (srst),
    .phase (flashPhase),
    .tick  ()
  );

  tsc_flash_timer #(
    .HALF_CYC (BUZZ_HALF_CYC)
  ) uBuzz (
    .clk   (clk),
    .srst  (srst),
    .phase (buzzPhase),
    .tick  ()
  );

  tsc_flash_timer #(
    .HALF_CYC (IDLE_TICK_CYC)
  ) uIdleTick (
    .clk   (clk),
    .srst  (srst),
    .phase (),
    .tick  (idleTick)
  );

  tsc_pin_sync uTouch (
    .clk   (clk),
    .srst  (srst),
    .pinIn (touchActivity),
    .level (touchLevel),
    .rise  (touchRise)
  );

  // Inactivity blanking
  tsc_pkg::tsc_idle_state_t idleState_ff;
  tsc_pkg::tsc_idle_state_t nxt_idleState;
  logic [15:0]              idleCount_ff;
  logic                     blankEn;
  logic                     blankBacklight;
  logic                     touched;

  assign blankEn        = cfg_ff[tsc_pkg::CFG_BLANK_EN];
  assign blankBacklight = cfg_ff[tsc_pkg::CFG_BLANK_BL];
  assign touched        = touchRise || touchLevel;

  always_comb
  begin
    nxt_idleState = idleState_ff;
    case (idleState_ff)
      tsc_pkg::IDLE_RUN:
      begin
        if (blankEn && !touched && (idlePeriod_ff != 16'h0000) &&
            (idleCount_ff >= idlePeriod_ff))
        begin
          nxt_idleState = tsc_pkg::IDLE_BLANK;
        end
      end
      tsc_pkg::IDLE_BLANK:
      begin
        if (touched || !blankEn)
        begin
          nxt_idleState = tsc_pkg::IDLE_RUN;
        end
      end
      default:
      begin
        nxt_idleState = tsc_pkg::IDLE_RUN;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      idleState_ff <= tsc_pkg::IDLE_RUN;
    end
    else
    begin
      idleState_ff <= nxt_idleState;
    end
  end

  // Counts idle ticks, restarting on any operator activity
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      idleCount_ff <= 16'h0000;
    end
    else if (touched || !blankEn || (idleState_ff != tsc_pkg::IDLE_RUN))
    begin
      idleCount_ff <= 16'h0000;
    end
    else if (idleTick && (idleCount_ff != 16'hFFFF))
    begin
      idleCount_ff <= idleCount_ff + 16'h0001;
    end
  end

  // Display, backlight and buzzer drive
  logic blanked;
  logic displayOn_ff;
  logic backlightOn_ff;
  logic backlightRed_ff;
  logic buzzerOn_ff;

  assign blanked = idleState_ff == tsc_pkg::IDLE_BLANK;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      displayOn_ff   <= 1'b0;
      backlightOn_ff <= 1'b0;
    end
    else
    begin
      displayOn_ff   <= enDisp && !(blanked && !blankBacklight);
      backlightOn_ff <= enDisp && !(blanked && blankBacklight);
    end
  end

  // Colour only counts while bit 15 of the applied word is set, even if blanking turns the backlight off
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      backlightRed_ff <= 1'b0;
    end
    else if (!enDisp)
    begin
      backlightRed_ff <= 1'b0;
    end
    else
    begin
      case (blMode)
        tsc_pkg::BL_RED:       backlightRed_ff <= 1'b1;
        tsc_pkg::BL_RED_FLASH: backlightRed_ff <= flashPhase;
        default:               backlightRed_ff <= 1'b0;
      endcase
    end
  end

  // Continuous takes priority over intermittent
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      buzzerOn_ff <= 1'b0;
    end
    else if (buzCont)
    begin
      buzzerOn_ff <= 1'b1;
    end
    else if (buzInt)
    begin
      buzzerOn_ff <= buzzPhase;
    end
    else
    begin
      buzzerOn_ff <= 1'b0;
    end
  end

  // Lamp and touch switch drive
  logic [NUM_LAMPS-1:0] lampLit_ff;
  logic [NUM_LAMPS-1:0] lampCtrlW;
  logic [NUM_LAMPS-1:0] lampAttrW;

  always_comb
  begin
    lampCtrlW     = '0;
    lampAttrW     = '0;
    lampCtrlW[LW-1:0] = lampCtrl_ff[LW-1:0];
    lampAttrW[LW-1:0] = lampAttr_ff[LW-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      lampLit_ff <= '0;
    end
    else
    begin
      lampLit_ff <= lampCtrlW & (~lampAttrW | {NUM_LAMPS{flashPhase}});
    end
  end

  // Read data, registered in the setup phase
  logic [31:0] statusWord;
  logic [31:0] lampOutWord;
  logic [31:0] prdata_ff;

  always_comb
  begin
    statusWord                        = 32'h0000_0000;
    statusWord[tsc_pkg::STAT_DISP]    = displayOn_ff;
    statusWord[tsc_pkg::STAT_BL]      = backlightOn_ff;
    statusWord[tsc_pkg::STAT_RED]     = backlightRed_ff;
    statusWord[tsc_pkg::STAT_BUZ]     = buzzerOn_ff;
    statusWord[tsc_pkg::STAT_BLANK]   = blanked;
    statusWord[tsc_pkg::STAT_APPLIED] = appliedFlag_ff;
    lampOutWord                       = 32'h0000_0000;
    lampOutWord[LW-1:0]               = lampLit_ff[LW-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prdata_ff <= 32'h0000_0000;
    end
    else if (rdSetup)
    begin
      case (paddr)
        tsc_pkg::OFS_CTRL: prdata_ff <= {16'h0000, ctrlWord_ff};
        tsc_pkg::OFS_LAMP: prdata_ff <= {16'h0000, lampCtrl_ff};
        tsc_pkg::OFS_ATTR: prdata_ff <= {16'h0000, lampAttr_ff};
        tsc_pkg::OFS_CFG:  prdata_ff <= {30'h0000_0000, cfg_ff};
        tsc_pkg::OFS_IDLE: prdata_ff <= {16'h0000, idlePeriod_ff};
        tsc_pkg::OFS_STAT: prdata_ff <= statusWord;
        tsc_pkg::OFS_LOUT: prdata_ff <= lampOutWord;
        default:           prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata       = prdata_ff;
  assign displayOn    = displayOn_ff;
  assign backlightOn  = backlightOn_ff;
  assign backlightRed = backlightRed_ff;
  assign buzzerOn     = buzzerOn_ff;
  assign lampLit      = lampLit_ff;

endmodule // tsc_status_control
`default_nettype wire

// [tb/tsc_status_control_chk.sv]
// Port-level assertions for the status-control block
`timescale 1ns/1ps
`default_nettype none
module tsc_status_control_chk #(
  parameter int NUM_LAMPS = 16
) (
  input wire logic                 clk,          // Clock
  input wire logic                 srst,         // Reset
  input wire logic                 psel,         // Select
  input wire logic                 penable,      // Enable
  input wire logic                 pwrite,       // Direction
  input wire logic [7:0]           paddr,        // Address
  input wire logic [31:0]          pwdata,       // Write data
  input wire logic [3:0]           pstrb,        // Strobes
  input wire logic                 pslverr,      // Error
  input wire logic                 displayOn,    // Display
  input wire logic                 backlightOn,  // Backlight
  input wire logic                 backlightRed, // Colour
  input wire logic                 buzzerOn,     // Buzzer
  input wire logic [NUM_LAMPS-1:0] lampLit       // Lamps
);
  logic acc;
  logic wc;
  logic blankEn_ff;
  assign acc = psel && penable && pwrite;
  // Blanking may hide the display, so control checks skip while it is enabled
  assign wc = acc && paddr == tsc_pkg::OFS_CTRL && pstrb[1] && !blankEn_ff;
  always_ff @(posedge clk)
  begin
    if (srst)
      blankEn_ff <= 1'b0;
    else if (acc && paddr == tsc_pkg::OFS_CFG && pstrb[0])
      blankEn_ff <= pwdata[0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  quiet_boot_a:
    assert property ($fell(srst) |-> (!displayOn && !backlightOn && !buzzerOn) [*3])
      else $error("output active after reset");
  bl_off_a:
    assert property (wc && !pwdata[15] |-> ##3 (!displayOn && !backlightOn && !backlightRed) [*3])
      else $error("backlight not off");
  disp_on_a:
    assert property (wc && pwdata[15] |-> ##3 displayOn && backlightOn)
      else $error("display not on");
  red_steady_a:
    assert property (wc && pwdata[15] && pwdata[11] && pwdata[10] |-> ##3 backlightRed [*3])
      else $error("backlight not red");
  white_a:
    assert property (wc && pwdata[15] && !pwdata[11] |-> ##3 !backlightRed [*3])
      else $error("backlight not white");
  red_flash_a:
    assert property (wc && pwdata[15] && pwdata[11] && !pwdata[10] |-> ##[3:12] $changed(backlightRed))
      else $error("backlight not flashing");
  buz_cont_a:
    assert property (wc && pwdata[13] |-> ##3 buzzerOn [*3])
      else $error("buzzer not steady");
  buz_int_a:
    assert property (wc && !pwdata[13] && pwdata[12] |-> ##[3:11] $changed(buzzerOn))
      else $error("buzzer not pulsing");
  buz_off_a:
    assert property (wc && !pwdata[13] && !pwdata[12] |-> ##3 !buzzerOn [*3])
      else $error("buzzer not silent");
  lamp_dark_a:
    assert property (acc && paddr == tsc_pkg::OFS_LAMP && (&pstrb[1:0])
      |-> ##2 (lampLit & ~$past(pwdata[NUM_LAMPS-1:0], 2)) == '0)
      else $error("lamp lit with bit clear");
  unmapped_a:
    assert property (psel && penable && paddr > tsc_pkg::OFS_LOUT |-> pslverr)
      else $error("no error on unmapped address");
endmodule // tsc_status_control_chk
`default_nettype wire

// [tb/tsc_ctrl_host.sv]
// Bus-master model of the controller writing the status words
`timescale 1ns/1ps
`default_nettype none
module tsc_ctrl_host (
  input  wire logic        clk,     // Clock
  output var  logic        psel,    // Select
  output var  logic        penable, // Enable
  output var  logic        pwrite,  // Direction
  output var  logic [7:0]  paddr,   // Address
  output var  logic [31:0] pwdata,  // Write data
  output var  logic [3:0]  pstrb,   // Strobes
  input  wire logic [31:0] prdata,  // Read data
  input  wire logic        pready,  // Ready
  input  wire logic        pslverr  // Error
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // tsc_ctrl_host
`default_nettype wire

// [tb/tsc_status_control_tb.sv]
// Self-checking bench for the status-control block
`timescale 1ns/1ps
`default_nettype none
module tsc_status_control_tb;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, touchActivity;
  logic        displayOn, backlightOn, backlightRed, buzzerOn, er;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] lampLit, w, l, a, orL, andL;
  logic [1:0]  t;
  int          mismatches, checkCount, cycles, nr, nb, hi;
  logic [7:0]  ofs [7] = '{tsc_pkg::OFS_CTRL, tsc_pkg::OFS_LAMP, tsc_pkg::OFS_ATTR,
                           tsc_pkg::OFS_CFG, tsc_pkg::OFS_IDLE, tsc_pkg::OFS_STAT,
                           tsc_pkg::OFS_LOUT};
  logic [15:0] rv [7] = '{tsc_pkg::CTRL_RST, tsc_pkg::LAMP_RST, tsc_pkg::ATTR_RST,
                          {14'h0, tsc_pkg::CFG_RST}, tsc_pkg::IDLE_RST, 16'h0, 16'h0};
  logic [15:0] words [10] = '{16'h00FF, 16'h8000, 16'h8000, 16'hB000, 16'h9000,
                              16'h8800, 16'h8C00, 16'h8400, 16'h0C00, 16'h8000};

  tsc_status_control #(
    .NUM_LAMPS(16), .FLASH_HALF_CYC(4), .BUZZ_HALF_CYC(3), .IDLE_TICK_CYC(5)
  ) tsc_status_control_inst (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .touchActivity(touchActivity), .displayOn(displayOn),
    .backlightOn(backlightOn), .backlightRed(backlightRed), .buzzerOn(buzzerOn),
    .lampLit(lampLit));
  tsc_ctrl_host tsc_ctrl_host_inst (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    tsc_ctrl_host_inst.xfer(1'b1, ad, d, rd, er);
  endtask
  task automatic rg(input logic [7:0] ad);
    tsc_ctrl_host_inst.xfer(1'b0, ad, 32'h0, rd, er);
  endtask

  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    touchActivity = 1'b0;
    void'($urandom(32'hAB6F));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      rg(ofs[i]);
      chk("resetValue", {16'h0, rv[i]}, rd);
    end
    wr(tsc_pkg::OFS_LOUT, 32'hFFFF);
    rg(tsc_pkg::OFS_LOUT);
    chk("readOnly", 32'h0, rd);
    rg(8'h1C);
    chk("slaveError", 32'h1, 32'(er));
    chk("unmappedData", 32'h0, rd);
    hi = 0;
    foreach (words[i])
    begin
      w = words[i];
      wr(tsc_pkg::OFS_CTRL, {16'h0, w});
      repeat (3) @(posedge clk);
      nr = 0;
      nb = 0;
      repeat (12)
      begin
        t = {backlightRed, buzzerOn};
        @(posedge clk);
        nr += int'(backlightRed !== t[1]);
        nb += int'(buzzerOn !== t[0]);
      end
      chk("displayOn", 32'(w[15]), 32'(displayOn));
      chk("backlightOn", 32'(w[15]), 32'(backlightOn));
      if (!w[15] || !w[11] || w[10])
        chk("backlightRed", 32'(w[15] & w[11] & w[10]), 32'(backlightRed));
      chk("redFlashing", 32'(w[15] & w[11] & ~w[10]), 32'(nr > 0));
      if (w[13] || !w[12])
        chk("buzzerOn", 32'(w[13]), 32'(buzzerOn));
      chk("buzzerPulsing", 32'(~w[13] & w[12]), 32'(nb > 0));
      rg(tsc_pkg::OFS_STAT);
      chk("applied", 32'(int'(w[15:8]) != hi), 32'(rd[5]));
      hi = int'(w[15:8]);
      wr(tsc_pkg::OFS_STAT, 32'h20);
    end
    repeat (4)
    begin
      l = 16'($urandom);
      a = 16'($urandom);
      wr(tsc_pkg::OFS_LAMP, {16'h0, l});
      wr(tsc_pkg::OFS_ATTR, {16'h0, a});
      repeat (3) @(posedge clk);
      orL = 16'h0;
      andL = 16'hFFFF;
      repeat (12)
      begin
        @(posedge clk);
        orL |= lampLit;
        andL &= lampLit;
      end
      chk("lampsSeen", {16'h0, l}, {16'h0, orL});
      chk("lampsSteady", {16'h0, l & ~a}, {16'h0, andL});
    end
    wr(tsc_pkg::OFS_IDLE, 32'h4);
    wr(tsc_pkg::OFS_CFG, 32'h1);
    repeat (60) @(posedge clk);
    chk("blankedDisplay", 32'h0, 32'(displayOn));
    touchActivity <= 1'b1;
    repeat (8) @(posedge clk);
    touchActivity <= 1'b0;
    chk("wokenDisplay", 32'h1, 32'(displayOn));
    wr(tsc_pkg::OFS_CFG, 32'h3);
    repeat (60) @(posedge clk);
    chk("blankedBacklight", 32'h0, 32'(backlightOn));
    print_verdict();
  end
endmodule // tsc_status_control_tb

bind tsc_status_control tsc_status_control_chk #(.NUM_LAMPS(NUM_LAMPS)) chk_inst (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pslverr(pslverr), .displayOn(displayOn),
  .backlightOn(backlightOn), .backlightRed(backlightRed), .buzzerOn(buzzerOn),
  .lampLit(lampLit));
`default_nettype wire
